// file: spaf_params.svh
`ifndef SPAF_PARAMS_SVH
`define SPAF_PARAMS_SVH

// Register addresses on the special function register port
`define SPAF_ADDR_SERIAL_CONTROL 8'h98
`define SPAF_ADDR_SERIAL_BUFFER  8'h99
`define SPAF_ADDR_POWER_CONTROL  8'h87
`define SPAF_ADDR_GIVEN_ADDRESS  8'ha9
`define SPAF_ADDR_ADDRESS_MASK   8'hb9

// Serial control register bit positions
`define SPAF_BIT_MODE_HI     7
`define SPAF_BIT_MODE_LO     6
`define SPAF_BIT_ADDR_FILTER 5
`define SPAF_BIT_RX_ENABLE   4
`define SPAF_BIT_TX_NINTH    3
`define SPAF_BIT_RX_NINTH    2
`define SPAF_BIT_TX_DONE     1
`define SPAF_BIT_RX_DONE     0

// Power control register bit positions used by the serial port
`define SPAF_BIT_RATE_DOUBLE 7
`define SPAF_BIT_FE_SELECT   6

// Reset values
`define SPAF_RST_SERIAL_CONTROL 8'h00
`define SPAF_RST_POWER_CONTROL  8'h00
`define SPAF_RST_GIVEN_ADDRESS  8'h00
`define SPAF_RST_ADDRESS_MASK   8'h00

// Timing: oscillator is sys_clk
`define SPAF_M0_BIT_CYCLES   12
`define SPAF_M0_PHASE_LAST   4'(`SPAF_M0_BIT_CYCLES - 1)
`define SPAF_M0_PHASE_HIGH   4'(`SPAF_M0_BIT_CYCLES / 2)
`define SPAF_OVERSAMPLE      16
`define SPAF_TICK_LAST       4'(`SPAF_OVERSAMPLE - 1)
`define SPAF_TICK_MID        4'(`SPAF_OVERSAMPLE / 2 - 1)
`define SPAF_M2_DIV_FAST     32
`define SPAF_M2_DIV_SLOW     64
`define SPAF_M2_PRE_FAST     2'(`SPAF_M2_DIV_FAST / `SPAF_OVERSAMPLE - 1)
`define SPAF_M2_PRE_SLOW     2'(`SPAF_M2_DIV_SLOW / `SPAF_OVERSAMPLE - 1)

// Frame lengths
`define SPAF_M0_BITS         4'd8
`define SPAF_M1_FRAME_BITS   4'd10
`define SPAF_M23_FRAME_BITS  4'd11
`define SPAF_M1_LAST_SAMPLE  4'd9
`define SPAF_M23_LAST_SAMPLE 4'd10

`endif

// file: spaf_pkg.sv
package spaf_pkg;
   // Transmit engine states
   typedef enum logic [1:0] {TX_IDLE, TX_UART, TX_SHIFT} spaf_tx_state_t;
   // Receive engine states
   typedef enum logic [1:0] {RX_IDLE, RX_UART, RX_SHIFT} spaf_rx_state_t;
   // Serial port modes as coded by the two mode-select bits
   typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIXED, MODE_UART9_VAR} spaf_mode_t;
endpackage

// file: spaf_serial_port.sv
// Summary of operation
// - Transmit and receive concurrently in modes 1 to 3, receive double-buffered
// - Buffer write feeds transmitter, read returns receiver
// - Mode 0 shifts 8 bits, clock at osc/12
// - Mode 1 frame start, 8 data, stop
// - Modes 2/3 add ninth bit, stop checked only for frame error
// - Mode 3 equals mode 2 except rate
// - Buffer write starts a transmission
// - Mode 0 receives while done clear, enabled
// - Other modes receive on start bit when enabled
// - Missing stop sets sticky frame error
// - Control bit 7 shows mode or error
// - Two mode bits select modes 0 to 3
// - Filter passes only ninth bit one bytes
// - Filter passes given or broadcast address only
// - Mode 1 filter also needs valid stop
// - Address filter ignored in mode 0
// - Given address uses mask don't-cares
// - Broadcast is address OR mask
// - Reset clears address and mask registers
`timescale 1ns/1ps
`include "spaf_params.svh"

// Transmit holding FIFO: flip-flop storage, depth must be a power of two
module spaf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Draining side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;     // Storage words
      logic [AW-1:0]               wr_ptr;  // Next slot to fill
      logic [AW-1:0]               rd_ptr;  // Oldest word
      logic [AW:0]                 count;   // Words held
      logic                        space;   // Not full
      logic                        avail;   // Not empty
   } spaf_fifo_state_t;

   spaf_fifo_state_t st;
   spaf_fifo_state_t next_st;
   logic             push;
   logic             pop;

   assign push      = in_valid && st.space;
   assign pop       = out_ready && st.avail;
   assign in_ready  = st.space;
   assign out_valid = st.avail;
   assign out_data  = st.mem[st.rd_ptr];

   // Pointer and flag update; flags are registered so ready never depends on the drain combinationally
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data;
         next_st.wr_ptr         = st.wr_ptr + AW'(1);
      end
      if (pop) begin
         next_st.rd_ptr = st.rd_ptr + AW'(1);
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
      next_st.space = next_st.count != (AW+1)'(DEPTH);
      next_st.avail = next_st.count != '0;
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st       <= '0;
         st.space <= 1'b1;
      end else begin
         st <= next_st;
      end
   end
endmodule

// Serial port with automatic address recognition
module spaf_serial_port
   import spaf_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Special function register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // Sixteen-times bit rate pulse for modes 1 and 3
   input  wire logic       baud16_tick,
   // Serial pins
   input  wire logic       rxd_in,
   output logic            rxd_out,
   output logic            rxd_oe,
   output logic            txd,
   // Transmit buffer room
   output logic            tx_space
);
   typedef struct packed {
      logic            mode_select_hi;        // Mode bit, high
      logic            mode_select_lo;        // Mode bit, low
      logic            address_filter_enable; // Multiprocessor filter
      logic            rx_enable;             // Receiver enable
      logic            tx_ninth_bit;          // Ninth bit to send
      logic            rx_ninth_bit;          // Ninth bit received
      logic            tx_done_flag;          // Transmit complete
      logic            rx_done_flag;          // Receive complete
      logic            frame_error_flag;      // Sticky framing error
      logic            rate_double;           // Mode 2 at osc/32
      logic            frame_error_select;    // Bit 7 shows the error flag
      logic [7:0]      slave_given_address;   // Own address
      logic [7:0]      slave_address_mask;    // Address mask
      logic [7:0]      rx_holding;            // Receive buffer
      logic [7:0]      rdata;                 // Registered read data
      logic [2:0]      rx_sync;               // Pin synchroniser
      logic            rx_level;              // Filtered pin level
      logic            rx_prev;               // Filtered level one cycle back
      logic [1:0]      prescale;              // Mode 2 rate divider
      spaf_tx_state_t  tx_state;              // Transmitter state
      logic [10:0]     tx_shift;              // Outgoing frame
      logic [3:0]      tx_bits;               // Bits left to send
      logic [3:0]      tx_tick;               // Oversample count
      spaf_rx_state_t  rx_state;              // Receiver state
      logic [8:0]      rx_shift;              // Incoming bits
      logic [3:0]      rx_bits;               // Samples taken
      logic [3:0]      rx_tick;               // Oversample count
      logic [3:0]      m0_phase;              // Shift mode bit phase
      logic            txd;                   // Data or shift clock pin
      logic            rxd_out;               // Shift mode data out
      logic            rxd_oe;                // Shift mode data drive
   } spaf_state_t;

   spaf_state_t st;
   spaf_state_t next_st;

   spaf_mode_t  mode;         // Decoded mode
   logic        tick16;       // Oversample pulse for UART modes
   logic        sctl_wr;      // Control register write
   logic        fifo_valid;   // Byte waiting to send
   logic [7:0]  fifo_data;    // That byte
   logic        fifo_pop;     // Transmitter takes it
   logic        m0_rx_start;  // Shift mode receive begins
   logic        rx_fin;       // UART stop bit sampled
   logic [3:0]  rx_last;      // Index of stop sample
   logic [7:0]  rx_data;      // Received byte
   logic        rx_stop;      // Received stop level
   logic        rx_nine;      // Value for the ninth bit field
   logic        addr_given;   // Given address matches
   logic        addr_bcast;   // Broadcast address matches
   logic        rx_accept;    // Byte may be loaded

   assign mode       = spaf_mode_t'({st.mode_select_hi, st.mode_select_lo});
   // mode 2 rate is fixed, modes 1 and 3 follow the external rate pulse
   assign tick16     = (mode == MODE_UART9_FIXED)
                     ? (st.prescale == (st.rate_double ? `SPAF_M2_PRE_FAST : `SPAF_M2_PRE_SLOW))
                     : baud16_tick;
   assign sctl_wr    = sfr_wr && (sfr_addr == `SPAF_ADDR_SERIAL_CONTROL);
   // shift mode shares both pins, so its transfers are one at a time
   assign fifo_pop   = fifo_valid && (st.tx_state == TX_IDLE) && (st.rx_state != RX_SHIFT);
   assign m0_rx_start = (mode == MODE_SHIFT) && st.rx_enable && !st.rx_done_flag
                      && (st.tx_state == TX_IDLE) && !fifo_valid;
   assign rx_last    = (mode == MODE_UART8) ? `SPAF_M1_LAST_SAMPLE : `SPAF_M23_LAST_SAMPLE;
   assign rx_fin     = (st.rx_state == RX_UART) && tick16 && (st.rx_tick == `SPAF_TICK_MID)
                     && (st.rx_bits == rx_last);
   assign rx_stop    = st.rx_level;
   // mode 1 keeps the stop bit as the ninth bit, modes 2/3 the real ninth bit
   assign rx_data    = (mode == MODE_UART8) ? st.rx_shift[8:1] : st.rx_shift[7:0];
   assign rx_nine    = (mode == MODE_UART8) ? rx_stop : st.rx_shift[8];
   assign addr_given = ((rx_data ^ st.slave_given_address) & st.slave_address_mask) == 8'h00;
   assign addr_bcast = ((rx_data ^ (st.slave_given_address | st.slave_address_mask))
                     & (st.slave_given_address | st.slave_address_mask)) == 8'h00;
   // ninth bit (stop bit in mode 1) must be one and the address must hit
   assign rx_accept  = !st.rx_done_flag
                     && (!st.address_filter_enable || (rx_nine && (addr_given || addr_bcast)));

   // every buffer write goes into the transmit queue while it has room; writes to a full queue are dropped
   spaf_fifo #(
      .WIDTH (8),
      .DEPTH (8)
   ) u_tx_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (sfr_wr && (sfr_addr == `SPAF_ADDR_SERIAL_BUFFER)),
      .in_data   (sfr_wdata),
      .in_ready  (tx_space),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_pop)
   );

   // Next-state logic; hardware flag sets come after software writes so a set always wins
   always_comb begin
      next_st = st;
      // Pin synchroniser; a change counts once the second and third stages agree
      next_st.rx_sync = {st.rx_sync[1:0], rxd_in};
      if (st.rx_sync[1] == st.rx_sync[2]) begin
         next_st.rx_level = st.rx_sync[2];
      end
      next_st.rx_prev = st.rx_level;
      // Mode 2 rate divider runs freely
      next_st.prescale = tick16 ? 2'h0 : st.prescale + 2'h1;
      // Register writes
      if (sfr_wr) begin
         case (sfr_addr)
            `SPAF_ADDR_SERIAL_CONTROL: begin
               if (st.frame_error_select) begin
                  next_st.frame_error_flag = sfr_wdata[`SPAF_BIT_MODE_HI];
               end else begin
                  next_st.mode_select_hi = sfr_wdata[`SPAF_BIT_MODE_HI];
               end
               next_st.mode_select_lo        = sfr_wdata[`SPAF_BIT_MODE_LO];
               next_st.address_filter_enable = sfr_wdata[`SPAF_BIT_ADDR_FILTER];
               next_st.rx_enable             = sfr_wdata[`SPAF_BIT_RX_ENABLE];
               next_st.tx_ninth_bit          = sfr_wdata[`SPAF_BIT_TX_NINTH];
               next_st.rx_ninth_bit          = sfr_wdata[`SPAF_BIT_RX_NINTH];
               next_st.tx_done_flag          = sfr_wdata[`SPAF_BIT_TX_DONE];
               next_st.rx_done_flag          = sfr_wdata[`SPAF_BIT_RX_DONE];
            end
            `SPAF_ADDR_POWER_CONTROL: begin
               next_st.rate_double        = sfr_wdata[`SPAF_BIT_RATE_DOUBLE];
               next_st.frame_error_select = sfr_wdata[`SPAF_BIT_FE_SELECT];
            end
            `SPAF_ADDR_GIVEN_ADDRESS: next_st.slave_given_address = sfr_wdata;
            `SPAF_ADDR_ADDRESS_MASK:  next_st.slave_address_mask  = sfr_wdata;
            default: ;
         endcase
      end
      // Register reads; unmapped addresses return zero
      if (sfr_rd) begin
         case (sfr_addr)
            `SPAF_ADDR_SERIAL_CONTROL: next_st.rdata = {
               st.frame_error_select ? st.frame_error_flag : st.mode_select_hi,
               st.mode_select_lo, st.address_filter_enable, st.rx_enable,
               st.tx_ninth_bit, st.rx_ninth_bit, st.tx_done_flag, st.rx_done_flag};
            `SPAF_ADDR_SERIAL_BUFFER: next_st.rdata = st.rx_holding;
            `SPAF_ADDR_POWER_CONTROL: next_st.rdata = {st.rate_double, st.frame_error_select, 6'h00};
            `SPAF_ADDR_GIVEN_ADDRESS: next_st.rdata = st.slave_given_address;
            `SPAF_ADDR_ADDRESS_MASK:  next_st.rdata = st.slave_address_mask;
            default:                  next_st.rdata = 8'h00;
         endcase
      end
      // Transmitter
      case (st.tx_state)
         TX_IDLE: begin
            if (fifo_pop) begin
               if (mode == MODE_SHIFT) begin
                  next_st.tx_state = TX_SHIFT;
                  next_st.tx_shift = {3'h7, fifo_data};
                  next_st.tx_bits  = `SPAF_M0_BITS;
                  next_st.m0_phase = 4'h0;
               end else if (mode == MODE_UART8) begin
                  next_st.tx_state = TX_UART;
                  next_st.tx_shift = {2'h3, fifo_data, 1'b0};
                  next_st.tx_bits  = `SPAF_M1_FRAME_BITS;
                  next_st.tx_tick  = 4'h0;
               end else begin
                  next_st.tx_state = TX_UART;
                  next_st.tx_shift = {1'b1, st.tx_ninth_bit, fifo_data, 1'b0};
                  next_st.tx_bits  = `SPAF_M23_FRAME_BITS;
                  next_st.tx_tick  = 4'h0;
               end
            end
         end
         TX_UART: begin
            if (tick16) begin
               next_st.tx_tick = st.tx_tick + 4'h1;
               if (st.tx_tick == `SPAF_TICK_LAST) begin
                  next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
                  next_st.tx_bits  = st.tx_bits - 4'h1;
                  // Stop bit begins
                  if (st.tx_bits == 4'h2) begin
                     next_st.tx_done_flag = 1'b1;
                  end
                  if (st.tx_bits == 4'h1) begin
                     next_st.tx_state = TX_IDLE;
                  end
               end
            end
         end
         TX_SHIFT: begin
            next_st.m0_phase = st.m0_phase + 4'h1;
            if (st.m0_phase == `SPAF_M0_PHASE_LAST) begin
               next_st.m0_phase = 4'h0;
               next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
               next_st.tx_bits  = st.tx_bits - 4'h1;
               // Last data bit ends
               if (st.tx_bits == 4'h1) begin
                  next_st.tx_done_flag = 1'b1;
                  next_st.tx_state     = TX_IDLE;
               end
            end
         end
         default: next_st.tx_state = TX_IDLE;
      endcase
      // Receiver
      case (st.rx_state)
         RX_IDLE: begin
            // the filter bit plays no part in shift mode
            // A start is a falling edge, so a line left low after a missing stop starts no phantom frame
            if ((mode != MODE_SHIFT) && st.rx_enable && st.rx_prev && !st.rx_level) begin
               next_st.rx_state = RX_UART;
               next_st.rx_tick  = 4'h0;
               next_st.rx_bits  = 4'h0;
            end else if (m0_rx_start) begin
               next_st.rx_state = RX_SHIFT;
               next_st.rx_bits  = 4'h0;
               next_st.m0_phase = 4'h0;
            end
         end
         RX_UART: begin
            if (tick16) begin
               next_st.rx_tick = st.rx_tick + 4'h1;
               if (st.rx_tick == `SPAF_TICK_MID) begin
                  next_st.rx_bits = st.rx_bits + 4'h1;
                  if ((st.rx_bits == 4'h0) && st.rx_level) begin
                     // Glitch, not a start bit
                     next_st.rx_state = RX_IDLE;
                  end else if (rx_fin) begin
                     next_st.rx_state = RX_IDLE;
                     if (!rx_stop) begin
                        next_st.frame_error_flag = 1'b1;
                     end
                     if (rx_accept) begin
                        next_st.rx_holding   = rx_data;
                        next_st.rx_ninth_bit = rx_nine;
                        next_st.rx_done_flag = 1'b1;
                     end
                  end else if (st.rx_bits != 4'h0) begin
                     next_st.rx_shift = {st.rx_level, st.rx_shift[8:1]};
                  end
               end
            end
         end
         RX_SHIFT: begin
            next_st.m0_phase = st.m0_phase + 4'h1;
            if (st.m0_phase == `SPAF_M0_PHASE_LAST) begin
               next_st.m0_phase = 4'h0;
               next_st.rx_shift = {st.rx_level, st.rx_shift[8:1]};
               next_st.rx_bits  = st.rx_bits + 4'h1;
               if (st.rx_bits == `SPAF_M0_BITS - 4'h1) begin
                  next_st.rx_holding   = {st.rx_level, st.rx_shift[8:2]};
                  next_st.rx_done_flag = 1'b1;
                  next_st.rx_state     = RX_IDLE;
               end
            end
         end
         default: next_st.rx_state = RX_IDLE;
      endcase
      // Pin drive: frame bit in UART modes, shift clock low then high in shift mode
      if (next_st.tx_state == TX_UART) begin
         next_st.txd = next_st.tx_shift[0];
      end else if ((next_st.tx_state == TX_SHIFT) || (next_st.rx_state == RX_SHIFT)) begin
         next_st.txd = next_st.m0_phase >= `SPAF_M0_PHASE_HIGH;
      end else begin
         next_st.txd = 1'b1;
      end
      next_st.rxd_oe  = next_st.tx_state == TX_SHIFT;
      next_st.rxd_out = next_st.tx_shift[0];
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st                     <= '0;
         st.slave_given_address <= `SPAF_RST_GIVEN_ADDRESS;
         st.slave_address_mask  <= `SPAF_RST_ADDRESS_MASK;
         st.rx_sync             <= 3'h7;
         st.rx_level            <= 1'b1;
         st.rx_prev             <= 1'b1;
         st.txd                 <= 1'b1;
         st.rxd_out             <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign sfr_rdata = st.rdata;
   assign txd       = st.txd;
   assign rxd_out   = st.rxd_out;
   assign rxd_oe    = st.rxd_oe;

   a_tx_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fifo_pop |=> st.tx_state != TX_IDLE) else $error("queued byte not started");
   a_m0_rx_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st.rx_state == RX_IDLE) && m0_rx_start |=> st.rx_state == RX_SHIFT)
      else $error("shift receive not started");
   a_rx_needs_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st.rx_state == RX_IDLE) && !st.rx_enable |=> st.rx_state == RX_IDLE)
      else $error("receive began while disabled");
   a_frame_err_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st.frame_error_flag && !sctl_wr |=> st.frame_error_flag) else $error("error flag lost");
   a_bit7_view: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sfr_rd && (sfr_addr == `SPAF_ADDR_SERIAL_CONTROL) |=>
      sfr_rdata[7] == ($past(st.frame_error_select) ? $past(st.frame_error_flag) : $past(st.mode_select_hi)))
      else $error("bit 7 view wrong");
   a_ninth_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rx_fin && st.address_filter_enable && !rx_nine && !st.rx_done_flag && !sctl_wr |=> !st.rx_done_flag)
      else $error("data byte passed filter");
   a_addr_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rx_fin && st.address_filter_enable && !addr_given && !addr_bcast && !sctl_wr |=>
      st.rx_done_flag == $past(st.rx_done_flag)) else $error("foreign address passed");
   a_rx_no_overwrite: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st.rx_done_flag && !sctl_wr |=> $stable(st.rx_holding) && st.rx_done_flag)
      else $error("unread byte overwritten");
   a_tx_done_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st.tx_done_flag && !sctl_wr |=> st.tx_done_flag) else $error("transmit flag cleared");
   a_m0_clock_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st.tx_state == TX_SHIFT) && $rose(st.txd) |-> st.txd [*6]) else $error("shift clock high short");
   a_reset_addr: assert property (@(posedge sys_clk)
      !rst_n |=> (st.slave_given_address == 8'h00) && (st.slave_address_mask == 8'h00))
      else $error("address registers not cleared");
endmodule

// file: spaf_remote_node.sv
`timescale 1ns/1ps
// Remote serial node sending 9-bit frames at 32 clocks a bit
module spaf_remote_node (
   // Clock
   input  wire logic sys_clk,
   // Line into the device, idles high as with a pull-up
   output logic      line
);
   initial line = 1'b1;
   // Start 0, data lsb first, ninth bit, stop; a bad stop is asked for by the caller
   task automatic send(input logic [7:0] d, input logic nine, input logic stop);
      logic [10:0] f;
      f = {stop, nine, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line = f[i];
         repeat (32) @(posedge sys_clk);
         // Move off the sampling edge, as the bench does
         #1;
      end
      line = 1'b1;
   endtask
endmodule

// file: spaf_serial_port_bench.sv
`timescale 1ns/1ps
`include "spaf_params.svh"
module spaf_serial_port_bench;
   import spaf_pkg::*;
   typedef struct {logic [7:0] d; logic nine; logic ok;} spaf_row_t;
   // Address frames against given f1, mask fa: given 1111_0x0x, broadcast 1111_1x11
   spaf_row_t rows [5] = '{'{8'hf0, 1, 1}, '{8'hf2, 1, 0}, '{8'hff, 1, 1}, '{8'hf0, 0, 0}, '{8'hf5, 1, 1}};
   logic       sys_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, rd;
   logic       rxd_in, rxd_out, rxd_oe, txd, tx_space;
   logic       b16 = 0;
   logic [10:0] f;
   int         err_count = 0, check_count = 0, n;
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   // Rate pulse on every second clock: 32 clocks a bit in modes 1 and 3, as the node sends
   always @(posedge sys_clk) b16 <= #1 ~b16;
   spaf_serial_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud16_tick(b16),
      .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .tx_space(tx_space));
   spaf_remote_node node (.sys_clk(sys_clk), .line(rxd_in));
   // Inputs move 1 ns after the edge
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   // Strobes drop for a cycle so back-to-back calls never re-raise them at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a; sfr_wdata = d; sfr_wr = 1; cyc(1); sfr_wr = 0; cyc(1);
   endtask
   task automatic rdr(input logic [7:0] a);
      sfr_addr = a; sfr_rd = 1; cyc(1); sfr_rd = 0; cyc(1); rd = sfr_rdata;
   endtask
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", nm, e, s);
         err_count++;
      end
   endtask
   task automatic end_of_test;
      if (err_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      cyc(3);
      rst_n = 1;
      chk("txd_idle", txd, 1); chk("tx_space", tx_space, 1);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("control", rd, 0);
      rdr(`SPAF_ADDR_GIVEN_ADDRESS); chk("given", rd, 0);
      rdr(`SPAF_ADDR_ADDRESS_MASK); chk("mask", rd, 0);
      wr(8'h10, 8'hff); rdr(8'h10); chk("unmapped", rd, 0);
      // Mode 2 at osc/32 with filter on, rx enabled
      wr(`SPAF_ADDR_POWER_CONTROL, 8'h80);
      wr(`SPAF_ADDR_GIVEN_ADDRESS, 8'hf1); wr(`SPAF_ADDR_ADDRESS_MASK, 8'hfa);
      foreach (rows[i]) begin
         wr(`SPAF_ADDR_SERIAL_CONTROL, 8'hb0);
         node.send(rows[i].d, rows[i].nine, 1);
         cyc(40);
         rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("rx_done", rd[0], rows[i].ok);
         if (rows[i].ok) begin
            rdr(`SPAF_ADDR_SERIAL_BUFFER); chk("rx_data", rd, rows[i].d);
         end
      end
      // Mode 1 with filter: the stop bit stands in for the ninth bit
      wr(`SPAF_ADDR_SERIAL_CONTROL, 8'h70);
      node.send(8'hff, 1, 1); cyc(40);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("m1_done", rd[0], 1);
      chk("m1_stop", rd[2], 1);
      rdr(`SPAF_ADDR_SERIAL_BUFFER); chk("m1_data", rd, 8'hff);
      wr(`SPAF_ADDR_SERIAL_CONTROL, 8'h70);
      node.send(8'hff, 0, 1); cyc(40);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("m1_bad_stop", rd[0], 0);
      // Mode 3: clear the error through bit 7, then a missing stop and a good frame while unread
      wr(`SPAF_ADDR_SERIAL_CONTROL, 8'hd0);
      wr(`SPAF_ADDR_POWER_CONTROL, 8'hc0);
      wr(`SPAF_ADDR_SERIAL_CONTROL, 8'h50);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("fe_clear", rd[7], 0);
      node.send(8'h3c, 0, 0); cyc(40);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("frame_err", rd[7], 1);
      node.send(8'h55, 0, 1); cyc(40);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("fe_sticky", rd[7], 1);
      rdr(`SPAF_ADDR_SERIAL_BUFFER); chk("no_overrun", rd, 8'h3c);
      // Transmit a mode 2 frame with ninth bit 1
      wr(`SPAF_ADDR_POWER_CONTROL, 8'h80);
      wr(`SPAF_ADDR_SERIAL_CONTROL, 8'h88);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("mode_bits", rd[7:6], 2'b10);
      wr(`SPAF_ADDR_SERIAL_BUFFER, 8'h35);
      f = {1'b1, 1'b1, 8'h35, 1'b0};
      for (n = 0; n < 100 && txd !== 1'b0; n++) cyc(1);
      if (n == 100) begin
         err_count++;
         end_of_test();
      end
      cyc(16);
      for (int b = 0; b < 11; b++) begin
         chk("txd_bit", txd, f[b]);
         cyc(32);
      end
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("tx_done", rd[1], 1);
      // Mode 0 transmit: data on the data pin, shift clock on txd
      wr(`SPAF_ADDR_SERIAL_CONTROL, 8'h00);
      wr(`SPAF_ADDR_SERIAL_BUFFER, 8'ha5);
      f = {3'h0, 8'ha5};
      for (n = 0; n < 50 && rxd_oe !== 1'b1; n++) cyc(1);
      if (n == 50) begin
         err_count++;
         end_of_test();
      end
      for (int b = 0; b < 8; b++) begin
         chk("m0_clk_low", txd, 0);
         cyc(6);
         chk("m0_clk_high", txd, 1);
         chk("m0_data", rxd_out, f[b]);
         cyc(6);
      end
      chk("m0_oe", rxd_oe, 0);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("m0_tx_done", rd[1], 1);
      // Mode 0 receive with the filter bit set; the idle line shifts in ones
      wr(`SPAF_ADDR_SERIAL_CONTROL, 8'h30);
      cyc(100);
      rdr(`SPAF_ADDR_SERIAL_CONTROL); chk("m0_rx_done", rd[0], 1);
      rdr(`SPAF_ADDR_SERIAL_BUFFER); chk("m0_rx_data", rd, 8'hff);
      // Reset in mid-run puts the address registers back to zero
      rst_n = 0; cyc(2); rst_n = 1;
      rdr(`SPAF_ADDR_GIVEN_ADDRESS); chk("given_again", rd, 0);
      chk("txd_again", txd, 1);
      end_of_test();
   end
endmodule
